// ===== logic/fxc_converter.sv
// Normalized fixed-point converter with version word pack and unpack
// Notes on behaviour
// - The fixed-point width b is the integer type width or the component width, fixed here at FXC_B.
// - Signed codes are b-bit two's complement and unsigned codes are plain b-bit magnitudes.
// - An unsigned code c converts to the float c divided by two to the b minus one, within zero to one.
// - A signed code c converts to the larger of minus one and c divided by two to the b-1 minus one.
// - The most negative signed code is clamped so it gives minus one like the code above it.
// - Float to unsigned clamps the input to zero to one and scales it by two to the b minus one.
// - The unsigned float-to-integer step returns a nearest b-bit code, rounding to nearest.
// - Float zero and one give the unsigned codes zero and all ones.
// - Float to signed clamps the input to minus one to one and scales it by two to the b-1 minus one.
// - The signed float-to-integer step returns a nearest code and the exact integer when the scaled value is integral.
// - Float minus one, zero and one give the signed codes minus max, zero and max.
// - The version word is 32 bits with a 10-bit major field in bits 31 to 22.
// - The minor field is 10 bits in bits 21 to 12.
// - The patch field is 12 bits in bits 11 to 0.
`timescale 1ns/1ns
module fxc_converter
  import fxc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  input wire logic [2:0] in_op,
  input wire logic [7:0] in_fixed,
  input wire logic [31:0] in_word,
  input wire logic [9:0] in_major,
  input wire logic [9:0] in_minor,
  input wire logic [11:0] in_patch,
  output logic out_valid,
  output logic [2:0] out_op,
  output logic [31:0] out_word,
  output logic [7:0] out_fixed,
  output logic [9:0] out_major,
  output logic [9:0] out_minor,
  output logic [11:0] out_patch
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic valid;
    fxc_op_type op;
    logic [31:0] word;
    logic [7:0] fixed;
    logic [9:0] major;
    logic [9:0] minor;
    logic [11:0] patch;
  } fxc_state_type;

  localparam fxc_state_type FXC_STATE_RESET = '{
    valid: 1'b0,
    op: FXC_OP_RESET,
    word: 32'h0000_0000,
    fixed: 8'h00,
    major: 10'h000,
    minor: 10'h000,
    patch: 12'h000
  };

  fxc_state_type st_r;
  fxc_state_type st_nxt;

  // ==========================================================================
  // Fixed to float
  // ==========================================================================
  // Both directions are single-cycle combinational paths into one register
  // stage. The division by the end code is the long pole; a faster clock
  // would need the quotient split over more stages, which would change the
  // fixed latency seen by the neighbouring pipeline.
  //
  // Builds a rounded float from a quotient with FXC_Q_FRAC fraction bits.
  // The quotient of a nonzero code is at least 2^40/255, so the leading one
  // sits in bits 32..40 and at least eight bits remain below the guard bit.
  function automatic logic [31:0] quot_to_float(input logic neg, input logic [FXC_Q_W-1:0] q,
                                                input logic rem_nz);
    logic [FXC_Q_W-1:0] qn;
    logic [5:0] lead;
    logic [23:0] mant;
    logic [7:0] expo;
    logic guard;
    logic sticky;
    lead = 6'h00;
    for (int i = 0; i <= FXC_Q_FRAC; i++) begin
      if (q[i]) begin
        lead = 6'(i);
      end
    end
    qn = q << (6'(FXC_Q_FRAC) - lead);
    mant = {1'b0, qn[FXC_Q_FRAC-1 -: FXC_F_MANT_W]};
    guard = qn[FXC_Q_FRAC-1-FXC_F_MANT_W];
    sticky = (|qn[FXC_Q_FRAC-2-FXC_F_MANT_W:0]) | rem_nz;
    expo = FXC_F_BIAS + 8'(lead) - 8'(FXC_Q_FRAC);
    // Round to nearest even; a carry out of the mantissa bumps the exponent
    mant = mant + 24'(guard & (sticky | mant[0]));
    if (mant[FXC_F_MANT_W]) begin
      expo = expo + 8'h01;
    end
    return {neg, expo, mant[FXC_F_MANT_W-1:0]};
  endfunction : quot_to_float

  function automatic logic [31:0] unorm_to_float(input logic [7:0] c);
    logic [FXC_Q_W-1:0] num;
    logic [FXC_Q_W-1:0] q;
    logic [FXC_Q_W-1:0] r;
    num = {c, 40'h00_0000_0000};
    q = num / {40'h00_0000_0000, FXC_UNORM_MAX};
    r = num % {40'h00_0000_0000, FXC_UNORM_MAX};
    if (c == 8'h00) begin
      return FXC_F_ZERO;
    end
    return quot_to_float(1'b0, q, r != 48'h0000_0000_0000);
  endfunction : unorm_to_float

  function automatic logic [31:0] snorm_to_float(input logic [7:0] c);
    logic [7:0] mag;
    logic [FXC_Q_W-1:0] num;
    logic [FXC_Q_W-1:0] q;
    logic [FXC_Q_W-1:0] r;
    mag = c[7] ? (8'h00 - c) : c;
    // The lowest code has no positive twin; clamping it keeps the result at -1.0
    if (c == FXC_SNORM_LOW) begin
      mag = FXC_SNORM_MAX;
    end
    num = {mag, 40'h00_0000_0000};
    q = num / {40'h00_0000_0000, FXC_SNORM_MAX};
    r = num % {40'h00_0000_0000, FXC_SNORM_MAX};
    if (mag == 8'h00) begin
      return FXC_F_ZERO;
    end
    return quot_to_float(c[7], q, r != 48'h0000_0000_0000);
  endfunction : snorm_to_float

  // ==========================================================================
  // Float to fixed
  // ==========================================================================
  logic [7:0] norm_code;

  fxc_float_to_norm u_float_to_norm (
    .fval(in_word),
    .signed_mode(in_op == FXC_OP_FLOAT_TO_SNORM),
    .code(norm_code)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Unknown op codes still answer, with zero results, so the valid stream
  // keeps one result per accepted operand.
  // Result fields of the other ops are zeroed on every accepted operand, so a
  // consumer that reads the wrong field sees zero rather than stale data.
  // Without an operand the data fields hold, which saves toggling power on
  // the wide result bus while the pipeline is idle.
  // The patch restart on a minor advance is left to whoever assigns version
  // numbers; the packer stores the fields exactly as given.
  always_comb begin
    st_nxt = st_r;
    st_nxt.valid = in_valid;
    if (in_valid) begin
      st_nxt.op = fxc_op_type'(in_op);
      st_nxt.word = 32'h0000_0000;
      st_nxt.fixed = 8'h00;
      st_nxt.major = 10'h000;
      st_nxt.minor = 10'h000;
      st_nxt.patch = 12'h000;
      case (in_op)
        FXC_OP_UNORM_TO_FLOAT: begin
          st_nxt.word = unorm_to_float(in_fixed);
        end
        FXC_OP_SNORM_TO_FLOAT: begin
          st_nxt.word = snorm_to_float(in_fixed);
        end
        FXC_OP_FLOAT_TO_UNORM, FXC_OP_FLOAT_TO_SNORM: begin
          st_nxt.fixed = norm_code;
        end
        FXC_OP_VER_PACK: begin
          st_nxt.word[FXC_VMAJ_LSB +: FXC_VMAJ_W] = in_major;
          st_nxt.word[FXC_VMIN_LSB +: FXC_VMIN_W] = in_minor;
          st_nxt.word[FXC_VPAT_LSB +: FXC_VPAT_W] = in_patch;
        end
        FXC_OP_VER_UNPACK: begin
          st_nxt.major = in_word[FXC_VMAJ_LSB +: FXC_VMAJ_W];
          st_nxt.minor = in_word[FXC_VMIN_LSB +: FXC_VMIN_W];
          st_nxt.patch = in_word[FXC_VPAT_LSB +: FXC_VPAT_W];
        end
        default: begin
          st_nxt.word = 32'h0000_0000;
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= FXC_STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs are plain wires from the state register, with no logic after it
  always_comb begin
    out_valid = st_r.valid;
    out_op = st_r.op;
    out_word = st_r.word;
    out_fixed = st_r.fixed;
    out_major = st_r.major;
    out_minor = st_r.minor;
    out_patch = st_r.patch;
  end

endmodule : fxc_converter

// ===== logic/fxc_float_to_norm.sv
// Float to normalized fixed-point conversion, combinational
`timescale 1ns/1ns
module fxc_float_to_norm
  import fxc_pkg::*;
(
  input wire logic [31:0] fval,
  input wire logic signed_mode,
  output logic [7:0] code
);

  // ==========================================================================
  // Scale by the end code and round to nearest
  // ==========================================================================
  // Only called for |f| < 1, so the shift never drops below 24
  function automatic logic [7:0] scale_round(input logic [23:0] m, input logic [7:0] e, input logic [7:0] d);
    logic [39:0] prod;
    logic [39:0] half;
    logic [39:0] sum;
    logic [7:0] sh;
    prod = {16'h0000, m} * {32'h0000_0000, d};
    sh = FXC_F_SHIFT_BASE - e;
    half = 40'h00_0000_0001 << (sh - 8'h01);
    sum = prod + half;
    sum = sum >> sh;
    return sum[7:0];
  endfunction : scale_round

  function automatic logic [7:0] clamp_mag(input logic [31:0] f, input logic [7:0] d);
    logic [7:0] e;
    logic [23:0] m;
    e = f[30:23];
    m = {(e != 8'h00), f[22:0]};
    if (e == FXC_F_EXP_MAX && f[22:0] != 23'h000000) begin
      return 8'h00;
    end else if (e >= FXC_F_BIAS) begin
      return d;
    end else if (e <= FXC_F_TINY_EXP) begin
      return 8'h00;
    end else begin
      return scale_round(m, e, d);
    end
  endfunction : clamp_mag

  function automatic logic [7:0] float_to_unsigned_round(input logic [31:0] f);
    if (f[31]) begin
      return 8'h00;
    end
    return clamp_mag(f, FXC_UNORM_MAX);
  endfunction : float_to_unsigned_round

  function automatic logic [7:0] float_to_signed_round(input logic [31:0] f);
    logic [7:0] mag;
    mag = clamp_mag(f, FXC_SNORM_MAX);
    return f[31] ? (8'h00 - mag) : mag;
  endfunction : float_to_signed_round

  always_comb begin
    code = signed_mode ? float_to_signed_round(fval) : float_to_unsigned_round(fval);
  end

endmodule : fxc_float_to_norm

// ===== logic/fxc_pkg.sv
// Constants and types shared by the normalized fixed-point converter
package fxc_pkg;

  // ==========================================================================
  // Fixed-point width and end codes
  // ==========================================================================
  localparam int FXC_B = 8;
  localparam logic [7:0] FXC_UNORM_MAX = 8'hFF;
  localparam logic [7:0] FXC_SNORM_MAX = 8'h7F;
  localparam logic [7:0] FXC_SNORM_LOW = 8'h80;

  // ==========================================================================
  // Single-precision float layout
  // ==========================================================================
  localparam int FXC_F_MANT_W = 23;
  localparam logic [7:0] FXC_F_BIAS = 8'h7F;
  localparam logic [7:0] FXC_F_EXP_MAX = 8'hFF;
  localparam logic [7:0] FXC_F_SHIFT_BASE = 8'h96;
  localparam logic [7:0] FXC_F_TINY_EXP = 8'h74;
  localparam logic [31:0] FXC_F_ZERO = 32'h0000_0000;
  // Fraction bits kept by the fixed-to-float quotient
  localparam int FXC_Q_FRAC = 40;
  localparam int FXC_Q_W = 48;

  // ==========================================================================
  // Version word layout
  // ==========================================================================
  localparam int FXC_VMAJ_LSB = 22;
  localparam int FXC_VMAJ_W = 10;
  localparam int FXC_VMIN_LSB = 12;
  localparam int FXC_VMIN_W = 10;
  localparam int FXC_VPAT_LSB = 0;
  localparam int FXC_VPAT_W = 12;

  // ==========================================================================
  // Pipeline
  // ==========================================================================
  localparam int FXC_LATENCY = 1;

  typedef enum logic [2:0] {
    FXC_OP_UNORM_TO_FLOAT = 3'h0,
    FXC_OP_SNORM_TO_FLOAT = 3'h1,
    FXC_OP_FLOAT_TO_UNORM = 3'h2,
    FXC_OP_FLOAT_TO_SNORM = 3'h3,
    FXC_OP_VER_PACK = 3'h4,
    FXC_OP_VER_UNPACK = 3'h5
  } fxc_op_type;

  localparam fxc_op_type FXC_OP_RESET = FXC_OP_UNORM_TO_FLOAT;

endpackage : fxc_pkg

// ===== verification/fxc_converter_monitor.sv
// Concurrent checks on the normalized fixed-point converter ports
`timescale 1ns/1ns
module fxc_converter_monitor
  import fxc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  input wire logic [2:0] in_op,
  input wire logic [7:0] in_fixed,
  input wire logic [31:0] in_word,
  input wire logic [9:0] in_major,
  input wire logic [9:0] in_minor,
  input wire logic [11:0] in_patch,
  input wire logic out_valid,
  input wire logic [2:0] out_op,
  input wire logic [31:0] out_word,
  input wire logic [7:0] out_fixed,
  input wire logic [9:0] out_major,
  input wire logic [9:0] out_minor,
  input wire logic [11:0] out_patch
);
  // ==========================================
  // Operand copies one cycle old
  // ==========================================
  logic [31:0] word_q;
  logic [31:0] vf_q;
  logic [2:0] op_q;
  always_ff @(posedge clk) begin
    word_q <= in_word;
    vf_q <= {in_major, in_minor, in_patch};
    op_q <= in_op;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_lat; in_valid |=> out_valid && out_op == op_q; endproperty
  a_lat: assert property (p_lat) else $error("result missing one cycle after operand");
  property p_quiet; !in_valid |=> !out_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("result valid without operand");
  property p_rst; disable iff (1'b0) srst |=> !out_valid && out_word == 32'h0 && out_fixed == 8'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset did not clear results");
  property p_pack; in_valid && in_op == FXC_OP_VER_PACK |=> out_word == vf_q; endproperty
  a_pack: assert property (p_pack) else $error("version pack wrong");
  property p_unpack;
    in_valid && in_op == FXC_OP_VER_UNPACK |=> out_major == word_q[31:22] && out_minor == word_q[21:12]
      && out_patch == word_q[11:0];
  endproperty
  a_unpack: assert property (p_unpack) else $error("version unpack wrong");
  property p_uone; in_valid && in_op == FXC_OP_UNORM_TO_FLOAT && in_fixed == 8'hFF |=> out_word == 32'h3F800000; endproperty
  a_uone: assert property (p_uone) else $error("unsigned full code not one");
  property p_sclamp;
    in_valid && in_op == FXC_OP_SNORM_TO_FLOAT && in_fixed inside {8'h80, 8'h81} |=> out_word == 32'hBF800000;
  endproperty
  a_sclamp: assert property (p_sclamp) else $error("signed low codes not minus one");
  property p_uend; in_valid && in_op == FXC_OP_FLOAT_TO_UNORM && in_word == 32'h3F800000 |=> out_fixed == 8'hFF; endproperty
  a_uend: assert property (p_uend) else $error("float one not all ones");
  property p_send; in_valid && in_op == FXC_OP_FLOAT_TO_SNORM && in_word == 32'hBF800000 |=> out_fixed == 8'h81; endproperty
  a_send: assert property (p_send) else $error("float minus one not minus max");
endmodule : fxc_converter_monitor
bind fxc_converter fxc_converter_monitor fxc_converter_monitor_inst (.clk(clk), .srst(srst), .in_valid(in_valid),
  .in_op(in_op), .in_fixed(in_fixed), .in_word(in_word), .in_major(in_major), .in_minor(in_minor),
  .in_patch(in_patch), .out_valid(out_valid), .out_op(out_op), .out_word(out_word), .out_fixed(out_fixed),
  .out_major(out_major), .out_minor(out_minor), .out_patch(out_patch));

// ===== verification/fxc_result_sink.sv
// Downstream pipeline stand-in that counts result pulses
`timescale 1ns/1ns
module fxc_result_sink (
  input wire logic clk,
  input wire logic srst,
  input wire logic out_valid,
  output logic [15:0] seen_cnt
);
  // No back-pressure exists, so every pulse must be taken in its own cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      seen_cnt <= 16'h0;
    end else if (out_valid) begin
      seen_cnt <= seen_cnt + 16'h1;
    end
  end
endmodule : fxc_result_sink

// ===== verification/test_fxc_converter.sv
// Self-checking bench for the normalized fixed-point converter
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_fxc_converter
  import fxc_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic in_valid = 1'b0;
  logic [2:0] in_op = 3'h0;
  logic [7:0] in_fixed = 8'h0;
  logic [31:0] in_word = 32'h0;
  logic [9:0] in_major = 10'h0;
  logic [9:0] in_minor = 10'h0;
  logic [11:0] in_patch = 12'h0;
  logic out_valid;
  logic [2:0] out_op;
  logic [31:0] out_word;
  logic [7:0] out_fixed;
  logic [9:0] out_major;
  logic [9:0] out_minor;
  logic [11:0] out_patch;
  logic [15:0] seen_cnt;
  int fails = 0;
  int total_checks = 0;
  int n_ops = 0;
  fxc_converter fxc_converter_inst (.clk(clk), .srst(srst), .in_valid(in_valid), .in_op(in_op), .in_fixed(in_fixed),
    .in_word(in_word), .in_major(in_major), .in_minor(in_minor), .in_patch(in_patch), .out_valid(out_valid),
    .out_op(out_op), .out_word(out_word), .out_fixed(out_fixed), .out_major(out_major), .out_minor(out_minor),
    .out_patch(out_patch));
  fxc_result_sink fxc_result_sink_inst (.clk(clk), .srst(srst), .out_valid(out_valid), .seen_cnt(seen_cnt));
  initial begin
    forever #50 clk = ~clk;
  end
  // ==========================================
  // Shared drivers, entered at a falling edge
  // ==========================================
  task automatic run(input logic [2:0] op, input logic [7:0] fx, input logic [31:0] w, input logic [31:0] vf,
    input logic [31:0] ew, input logic [7:0] ef, input logic [31:0] ev);
    {in_valid, in_op, in_fixed, in_word, in_major, in_minor, in_patch} = {1'b1, op, fx, w, vf};
    @(negedge clk);
    n_ops++;
    `CHK({out_valid, out_op, out_word, out_fixed, out_major, out_minor, out_patch}, {1'b1, op, ew, ef, ev})
  endtask : run
  task automatic idle();
    logic [31:0] w0;
    w0 = out_word;
    in_valid = 1'b0;
    @(negedge clk);
    `CHK({out_valid, out_word}, {1'b0, w0})
  endtask : idle
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // ==========================================
  // Scenarios, back to back except the mid-run reset, which follows two idle cycles
  // ==========================================
  task automatic t_to_float();
    run(FXC_OP_UNORM_TO_FLOAT, 8'hFF, 32'h0, 32'h0, 32'h3F800000, 8'h0, 32'h0);
    run(FXC_OP_UNORM_TO_FLOAT, 8'h00, 32'h0, 32'h0, 32'h00000000, 8'h0, 32'h0);
    run(FXC_OP_UNORM_TO_FLOAT, 8'h01, 32'h0, 32'h0, 32'h3B808081, 8'h0, 32'h0);
    run(FXC_OP_SNORM_TO_FLOAT, 8'h7F, 32'h0, 32'h0, 32'h3F800000, 8'h0, 32'h0);
    run(FXC_OP_SNORM_TO_FLOAT, 8'h80, 32'h0, 32'h0, 32'hBF800000, 8'h0, 32'h0);
    run(FXC_OP_SNORM_TO_FLOAT, 8'h81, 32'h0, 32'h0, 32'hBF800000, 8'h0, 32'h0);
    run(FXC_OP_SNORM_TO_FLOAT, 8'h01, 32'h0, 32'h0, 32'h3C010204, 8'h0, 32'h0);
    run(FXC_OP_SNORM_TO_FLOAT, 8'hFF, 32'h0, 32'h0, 32'hBC010204, 8'h0, 32'h0);
  endtask : t_to_float
  task automatic t_to_unorm();
    run(FXC_OP_FLOAT_TO_UNORM, 8'h0, 32'h3F800000, 32'h0, 32'h0, 8'hFF, 32'h0);
    run(FXC_OP_FLOAT_TO_UNORM, 8'h0, 32'h00000000, 32'h0, 32'h0, 8'h00, 32'h0);
    run(FXC_OP_FLOAT_TO_UNORM, 8'h0, 32'h3F000000, 32'h0, 32'h0, 8'h80, 32'h0);
    run(FXC_OP_FLOAT_TO_UNORM, 8'h0, 32'h3B808081, 32'h0, 32'h0, 8'h01, 32'h0);
    run(FXC_OP_FLOAT_TO_UNORM, 8'h0, 32'hBF000000, 32'h0, 32'h0, 8'h00, 32'h0);
    run(FXC_OP_FLOAT_TO_UNORM, 8'h0, 32'h43000000, 32'h0, 32'h0, 8'hFF, 32'h0);
  endtask : t_to_unorm
  task automatic t_to_snorm();
    run(FXC_OP_FLOAT_TO_SNORM, 8'h0, 32'hBF800000, 32'h0, 32'h0, 8'h81, 32'h0);
    run(FXC_OP_FLOAT_TO_SNORM, 8'h0, 32'h00000000, 32'h0, 32'h0, 8'h00, 32'h0);
    run(FXC_OP_FLOAT_TO_SNORM, 8'h0, 32'h3F800000, 32'h0, 32'h0, 8'h7F, 32'h0);
    run(FXC_OP_FLOAT_TO_SNORM, 8'h0, 32'hBF000000, 32'h0, 32'h0, 8'hC0, 32'h0);
    run(FXC_OP_FLOAT_TO_SNORM, 8'h0, 32'h3C010204, 32'h0, 32'h0, 8'h01, 32'h0);
    run(FXC_OP_FLOAT_TO_SNORM, 8'h0, 32'hC0000000, 32'h0, 32'h0, 8'h81, 32'h0);
    run(FXC_OP_FLOAT_TO_SNORM, 8'h0, 32'h40000000, 32'h0, 32'h0, 8'h7F, 32'h0);
  endtask : t_to_snorm
  task automatic t_version();
    run(FXC_OP_VER_PACK, 8'h0, 32'h0, {10'h001, 10'h000, 12'h045}, 32'h00400045, 8'h0, 32'h0);
    // Minor advances, so the assigned patch restarts at zero
    run(FXC_OP_VER_PACK, 8'h0, 32'h0, {10'h001, 10'h001, 12'h000}, 32'h00401000, 8'h0, 32'h0);
    run(FXC_OP_VER_UNPACK, 8'h0, 32'hFFC00000, 32'h0, 32'h0, 8'h0, {10'h3FF, 10'h000, 12'h000});
    run(FXC_OP_VER_UNPACK, 8'h0, 32'h003FF000, 32'h0, 32'h0, 8'h0, {10'h000, 10'h3FF, 12'h000});
    run(FXC_OP_VER_UNPACK, 8'h0, 32'h00000FFF, 32'h0, 32'h0, 8'h0, {10'h000, 10'h000, 12'hFFF});
    run(3'h6, 8'hFF, 32'h3F800000, 32'hFFFFFFFF, 32'h0, 8'h0, 32'h0);
  endtask : t_version
  task automatic t_mid_reset();
    {srst, in_valid, in_op, in_word} = {1'b1, 1'b1, 3'h4, 32'h0};
    @(negedge clk);
    {srst, in_valid} = 2'b00;
    `CHK({out_valid, out_word, seen_cnt}, {1'b0, 32'h0, 16'h0})
    @(negedge clk);
  endtask : t_mid_reset
  initial begin
    repeat (12) @(negedge clk);
    srst = 1'b0;
    `CHK({out_valid, out_op, out_word, out_fixed, out_major, out_minor, out_patch}, 76'h0)
    t_to_float();
    t_to_unorm();
    t_to_snorm();
    t_version();
    idle();
    idle();
    `CHK(seen_cnt, n_ops[15:0])
    t_mid_reset();
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    wrap_up();
  end
endmodule : test_fxc_converter
